// file: vol_defs.svh
// offsets, field positions, reset values and timing counts for the volume
// control link; included by the device end, the host end and the bench
`ifndef VOL_DEFS_SVH
`define VOL_DEFS_SVH

// clock and timing
`define VOL_CLK_PERIOD_NS 5
`define VOL_AMP_SETTLE_NS 10000
`define VOL_AMP_SETTLE_CYC \
	((`VOL_AMP_SETTLE_NS + `VOL_CLK_PERIOD_NS - 1) / `VOL_CLK_PERIOD_NS)
`define VOL_MS_NS 1000000
`define VOL_MS_CYC (`VOL_MS_NS / `VOL_CLK_PERIOD_NS)
`define VOL_LINK_HALF_CYC 8
`define VOL_CSH_NS 1000
`define VOL_CSH_CYC \
	((`VOL_CSH_NS + `VOL_CLK_PERIOD_NS - 1) / `VOL_CLK_PERIOD_NS)
`define VOL_FRAME_BITS 24

// zero-crossing time-out choices in ms
`define VOL_TO_MS_0 5
`define VOL_TO_MS_1 10
`define VOL_TO_MS_2 15
`define VOL_TO_MS_3 20
`define VOL_TO_MS_4 25
`define VOL_TO_MS_5 30
`define VOL_TO_MS_6 40
`define VOL_TO_MS_7 50

// device register map
`define VOL_REG_CH_VOL_BASE 8'h01
`define VOL_REG_QTR 8'h09
`define VOL_REG_ZC_CFG 8'h0a
`define VOL_REG_GROUP 8'h0b
`define VOL_REG_PWR_ALL 8'h0c
`define VOL_REG_CH_PWR 8'h0d
`define VOL_REG_MASTER_BASE 8'h0e
`define VOL_MASTER_STRIDE 8'h03

// fields
`define VOL_ZC_MODE_BIT 0
`define VOL_ZC_POLICY_BIT 1
`define VOL_ZC_TO_LSB 2
`define VOL_GROUP_EN_BIT 7
`define VOL_PWR_ALL_BIT 0
`define VOL_CHIP_RW_BIT 0

// reset values
`define VOL_VOL_RST 8'h00
`define VOL_QTR_RST 8'h00
`define VOL_ZC_CFG_RST 8'h01
`define VOL_GROUP_RST 8'h00
`define VOL_PWR_ALL_RST 1'b1
`define VOL_CH_PWR_RST 8'h00
`define VOL_MASK_RST 8'hff

// level limits, signed quarter dB
`define VOL_LEVEL_MAX 12'sh058
`define VOL_LEVEL_MIN 12'she80

// host register map
`define VOL_H_CHIP 3'h0
`define VOL_H_MAP 3'h1
`define VOL_H_DATA 3'h2
`define VOL_H_STATUS 3'h3
`define VOL_H_CTRL 3'h4
`define VOL_H_RST_BIT 0

`endif

// file: vol_pkg.sv
// shared types of the volume control device and its host
// assumes vol_defs.svh is on the include path
package vol_pkg;
	typedef enum logic [1:0] {
		CH_OFF,
		CH_UP,
		CH_ON,
		CH_DOWN
	} chan_state_t;

	typedef enum logic [1:0] {
		H_IDLE,
		H_SHIFT,
		H_GAP
	} host_state_t;

	typedef logic signed [10:0] level_t;
endpackage : vol_pkg

// file: vol_link_if.sv
// three-wire serial link plus reset pin between host and volume device
// assumes the host drives every wire; the device only listens
interface vol_link_if;
	logic reset_n;
	logic link_clk;
	logic sel_n;
	logic sdata;

	modport host (
		output reset_n,
		output link_clk,
		output sel_n,
		output sdata
	);

	modport dev (
		input reset_n,
		input link_clk,
		input sel_n,
		input sdata
	);
endinterface : vol_link_if

// file: vol_device.sv
// volume device end: serial register port, power sequencing, volume engine
// assumes link wires and zero-cross comparators are asynchronous to core_clk_i
//
// Behaviour
// (R1) reset pin low: powered down, link ignored
// (R2) after reset, amps off while global_power_down set
// (R3) channel powers up only when both bits clear
// (R4) reset: channel bits clear, global bit set
// (R5) mute during amp power-up, then apply level
// (R6) either power-down bit set powers channel down
// (R7) mute channel before amp power-down starts
// (R8) power mute transitions obey zero-crossing timing
// (R9) host selects immediate mode for instant power
// (R10) reset low returns all settings to defaults
// (R11) host loads settings, then clears global bit
// (R12) host sets global bit, may then reset
// (R13) 118 dB span in quarter-dB steps
// (R14) changes immediate or at zero-crossing, configurable
// (R15) time-out from eight periods, 5-50 ms
// (R16) superseded command: apply earlier or discard
// (R17) eight individual controls, one per channel
// (R18) three maskable masters, one write each
// (R19) 128 device addresses plus group address
// (R20) master masks reset to all channels
// (R21) level is sum of masked terms, clamped
// (R22) time-out restarts on new change, clears on apply
//
// The implementer's own choice: the strobed register port.
`include "vol_defs.svh"

module vol_device #(
	parameter logic [6:0] DEV_ADDR = 7'h00,
	parameter int MS_CYC = `VOL_MS_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	vol_link_if.dev link,
	input wire logic [7:0] zero_cross_i,
	output logic [7:0] amp_enable_o,
	output logic [7:0] chan_mute_o,
	output logic [87:0] chan_level_o
);
	localparam logic [11:0] SETTLE_CYC = 12'(`VOL_AMP_SETTLE_CYC);
	localparam logic [5:0] TO_MS [8] = '{
		6'(`VOL_TO_MS_0), 6'(`VOL_TO_MS_1), 6'(`VOL_TO_MS_2),
		6'(`VOL_TO_MS_3), 6'(`VOL_TO_MS_4), 6'(`VOL_TO_MS_5),
		6'(`VOL_TO_MS_6), 6'(`VOL_TO_MS_7)};

	// two-stage synchronisers; stage one feeds stage two only
	logic [11:0] sync1_r;
	logic [11:0] sync2_r;
	logic [11:0] sync3_r;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_r <= 12'h000;
			sync2_r <= 12'h000;
			sync3_r <= 12'h000;
		end else if (ce_i) begin
			sync1_r <= {zero_cross_i, link.reset_n, link.link_clk,
				link.sel_n, link.sdata};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	logic pin_rst;
	logic lclk_rise;
	logic sel_rise;
	logic [7:0] zc_edge;
	assign pin_rst = !sync2_r[3]; // (R1)
	assign lclk_rise = sync2_r[2] && !sync3_r[2];
	assign sel_rise = sync2_r[1] && !sync3_r[1];
	assign zc_edge = sync2_r[11:4] ^ sync3_r[11:4]; // sign change

	// frame shifter; clocks outside a selected frame are not counted
	logic [23:0] shift_r;
	logic [4:0] bits_r;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			shift_r <= 24'h00_0000;
			bits_r <= 5'h00;
		end else if (ce_i) begin
			if (pin_rst || sync2_r[1]) begin // (R1)
				bits_r <= 5'h00;
			end else if (lclk_rise) begin
				shift_r <= {shift_r[22:0], sync2_r[0]};
				if (bits_r != 5'h1f)
					bits_r <= bits_r + 5'h01;
			end
		end
	end

	// a write lands when select rises after exactly one full frame
	logic [6:0] chip_id;
	logic addressed;
	logic wr_en;
	logic [7:0] wr_map;
	logic [7:0] wr_data;
	logic [7:0] group_r;
	assign chip_id = shift_r[23:17];
	assign wr_map = shift_r[15:8];
	assign wr_data = shift_r[7:0];
	assign addressed = (chip_id == DEV_ADDR) || // (R19)
		(group_r[`VOL_GROUP_EN_BIT] && chip_id == group_r[6:0]);
	assign wr_en = sel_rise && !pin_rst &&
		bits_r == 5'(`VOL_FRAME_BITS) && addressed &&
		!shift_r[16 + `VOL_CHIP_RW_BIT];

	// control registers; reset pin restores every default
	logic [7:0] vol_r [8];
	logic [7:0] qtr_r;
	logic [7:0] zc_cfg_r;
	logic pwr_all_r;
	logic [7:0] ch_pwr_r;
	logic [7:0] mvol_r [3];
	logic [7:0] mctl_r [3];
	logic [7:0] mmask_r [3];
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 8; i++)
				vol_r[i] <= `VOL_VOL_RST;
			for (int k = 0; k < 3; k++) begin
				mvol_r[k] <= `VOL_VOL_RST;
				mctl_r[k] <= `VOL_VOL_RST;
				mmask_r[k] <= `VOL_MASK_RST; // (R20)
			end
			qtr_r <= `VOL_QTR_RST;
			zc_cfg_r <= `VOL_ZC_CFG_RST;
			group_r <= `VOL_GROUP_RST;
			pwr_all_r <= `VOL_PWR_ALL_RST; // (R4)
			ch_pwr_r <= `VOL_CH_PWR_RST; // (R4)
		end else if (ce_i) begin
			if (pin_rst) begin // (R10)
				for (int i = 0; i < 8; i++)
					vol_r[i] <= `VOL_VOL_RST;
				for (int k = 0; k < 3; k++) begin
					mvol_r[k] <= `VOL_VOL_RST;
					mctl_r[k] <= `VOL_VOL_RST;
					mmask_r[k] <= `VOL_MASK_RST; // (R20)
				end
				qtr_r <= `VOL_QTR_RST;
				zc_cfg_r <= `VOL_ZC_CFG_RST;
				group_r <= `VOL_GROUP_RST;
				pwr_all_r <= `VOL_PWR_ALL_RST; // (R4)
				ch_pwr_r <= `VOL_CH_PWR_RST; // (R4)
			end else if (wr_en) begin
				for (int i = 0; i < 8; i++)
					if (wr_map == `VOL_REG_CH_VOL_BASE + 8'(i))
						vol_r[i] <= wr_data; // (R17)
				for (int k = 0; k < 3; k++) begin
					if (wr_map == `VOL_REG_MASTER_BASE +
						8'(k) * `VOL_MASTER_STRIDE)
						mvol_r[k] <= wr_data; // (R18)
					if (wr_map == `VOL_REG_MASTER_BASE +
						8'(k) * `VOL_MASTER_STRIDE + 8'h01)
						mctl_r[k] <= wr_data;
					if (wr_map == `VOL_REG_MASTER_BASE +
						8'(k) * `VOL_MASTER_STRIDE + 8'h02)
						mmask_r[k] <= wr_data; // (R18)
				end
				if (wr_map == `VOL_REG_QTR)
					qtr_r <= wr_data;
				if (wr_map == `VOL_REG_ZC_CFG)
					zc_cfg_r <= wr_data;
				if (wr_map == `VOL_REG_GROUP)
					group_r <= wr_data;
				if (wr_map == `VOL_REG_PWR_ALL)
					pwr_all_r <= wr_data[`VOL_PWR_ALL_BIT];
				if (wr_map == `VOL_REG_CH_PWR)
					ch_pwr_r <= wr_data;
			end
		end
	end

	// shared 1 ms tick; a time-out may therefore run up to 1 ms short
	logic [17:0] ms_cnt_r;
	logic ms_tick_r;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ms_cnt_r <= 18'h0_0000;
			ms_tick_r <= 1'b0;
		end else if (ce_i) begin
			ms_tick_r <= (ms_cnt_r == 18'(MS_CYC - 1));
			if (ms_cnt_r == 18'(MS_CYC - 1))
				ms_cnt_r <= 18'h0_0000;
			else
				ms_cnt_r <= ms_cnt_r + 18'h0_0001;
		end
	end

	logic zc_mode;
	logic zc_apply_prev;
	logic [5:0] to_limit;
	assign zc_mode = zc_cfg_r[`VOL_ZC_MODE_BIT]; // (R14)
	assign zc_apply_prev = zc_cfg_r[`VOL_ZC_POLICY_BIT];
	assign to_limit = TO_MS[zc_cfg_r[`VOL_ZC_TO_LSB +: 3]]; // (R15)

	// effective level per master, signed quarter dB
	logic signed [11:0] mlvl [3];
	always_comb begin
		for (int k = 0; k < 3; k++)
			mlvl[k] = {{3{mvol_r[k][7]}}, mvol_r[k], mctl_r[k][0]};
	end

	for (genvar i = 0; i < 8; i++) begin : g_chan
		logic signed [11:0] sum;
		vol_pkg::level_t eff;
		logic want_on;
		vol_pkg::chan_state_t st_r;
		logic [11:0] settle_r;
		logic [11:0] tgt;
		logic [11:0] cur;
		logic [11:0] app_r;
		logic [11:0] pend_val_r;
		logic pend_r;
		logic [5:0] tmo_r;
		logic amp_r;

		// individual term plus masked masters, clamped
		always_comb begin
			sum = {{3{vol_r[i][7]}}, vol_r[i], qtr_r[i]}; // (R13)
			for (int k = 0; k < 3; k++)
				if (mmask_r[k][i])
					sum = sum + mlvl[k]; // (R21)
			if (sum > `VOL_LEVEL_MAX)
				eff = 11'(`VOL_LEVEL_MAX); // (R21)
			else if (sum < `VOL_LEVEL_MIN)
				eff = 11'(`VOL_LEVEL_MIN);
			else
				eff = sum[10:0];
		end

		assign want_on = !pwr_all_r && !ch_pwr_r[i]; // (R3) (R6)
		assign tgt = {st_r != vol_pkg::CH_ON, eff}; // (R5) (R7)
		assign cur = pend_r ? pend_val_r : app_r;

		// power sequencing
		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				st_r <= vol_pkg::CH_OFF;
				amp_r <= 1'b0;
				settle_r <= 12'h000;
			end else if (ce_i) begin
				if (pin_rst) begin // (R1)
					st_r <= vol_pkg::CH_OFF;
					amp_r <= 1'b0;
				end else begin
					unique case (st_r)
					vol_pkg::CH_OFF: begin
						if (want_on) begin // (R2) (R3)
							st_r <= vol_pkg::CH_UP;
							amp_r <= 1'b1;
							settle_r <= SETTLE_CYC;
						end
					end
					vol_pkg::CH_UP: begin
						if (!want_on)
							st_r <= vol_pkg::CH_DOWN;
						else if (settle_r == 12'h000)
							st_r <= vol_pkg::CH_ON; // (R5)
						else
							settle_r <= settle_r - 12'h001;
					end
					vol_pkg::CH_ON: begin
						if (!want_on)
							st_r <= vol_pkg::CH_DOWN; // (R6)
					end
					vol_pkg::CH_DOWN: begin
						// amp goes off only once mute has really landed
						if (app_r[11] && !pend_r) begin // (R7)
							st_r <= vol_pkg::CH_OFF;
							amp_r <= 1'b0;
						end
					end
					endcase
				end
			end
		end

		// change engine: immediate or zero-crossing with time-out
		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				app_r <= 12'h800;
				pend_val_r <= 12'h800;
				pend_r <= 1'b0;
				tmo_r <= 6'h00;
			end else if (ce_i) begin
				if (pin_rst) begin
					app_r <= 12'h800;
					pend_r <= 1'b0;
					tmo_r <= 6'h00;
				end else if (!zc_mode) begin // (R8) (R14)
					app_r <= tgt;
					pend_r <= 1'b0;
					tmo_r <= 6'h00;
				end else if (tgt != cur) begin
					if (pend_r && zc_apply_prev)
						app_r <= pend_val_r; // (R16)
					pend_val_r <= tgt; // (R16)
					pend_r <= 1'b1;
					tmo_r <= 6'h00; // (R22)
				end else if (pend_r && (zc_edge[i] || tmo_r >= to_limit)) begin
					app_r <= pend_val_r; // (R8) (R15)
					pend_r <= 1'b0;
					tmo_r <= 6'h00; // (R22)
				end else if (pend_r && ms_tick_r) begin
					tmo_r <= tmo_r + 6'h01;
				end
			end
		end

		assign amp_enable_o[i] = amp_r;
		assign chan_mute_o[i] = app_r[11];
		assign chan_level_o[i*11 +: 11] = app_r[10:0];
	end
endmodule : vol_device

// file: vol_host.sv
// host end: turns register-port orders into serial write frames
// assumes the device samples data on rising link clock while select is low
`include "vol_defs.svh"

module vol_host (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [7:0] rdata_o,
	vol_link_if.host link
);
	logic [7:0] chip_r;
	logic [7:0] map_r;
	logic rst_pin_r;
	logic busy;
	logic launch;
	vol_pkg::host_state_t st_r;
	logic [23:0] frame_r;
	logic [4:0] bits_r;
	logic [7:0] div_r;
	logic lclk_r;
	logic [7:0] gap_r;

	assign busy = st_r != vol_pkg::H_IDLE;
	// data writes while busy are dropped; poll status first
	assign launch = we_i && addr_i == `VOL_H_DATA && !busy;

	// order registers; reset pin held low from reset (R10)
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			chip_r <= 8'h00;
			map_r <= 8'h00;
			rst_pin_r <= 1'b0; // (R10)
		end else if (ce_i && we_i) begin
			if (addr_i == `VOL_H_CHIP)
				chip_r <= wdata_i;
			if (addr_i == `VOL_H_MAP)
				map_r <= wdata_i;
			if (addr_i == `VOL_H_CTRL)
				rst_pin_r <= wdata_i[`VOL_H_RST_BIT]; // (R12)
		end
	end

	// read data one cycle after the strobe
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (ce_i) begin
			rdata_o <= 8'h00;
			if (re_i) begin
				unique case (addr_i)
				`VOL_H_CHIP: rdata_o <= chip_r;
				`VOL_H_MAP: rdata_o <= map_r;
				`VOL_H_STATUS: rdata_o <= {7'h00, busy};
				`VOL_H_CTRL: rdata_o <= {7'h00, rst_pin_r};
				default: rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// frame engine; data moves on falling edges, select gap afterwards
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= vol_pkg::H_IDLE;
			frame_r <= 24'h00_0000;
			bits_r <= 5'h00;
			div_r <= 8'h00;
			lclk_r <= 1'b0;
			gap_r <= 8'h00;
		end else if (ce_i) begin
			unique case (st_r)
			vol_pkg::H_IDLE: begin
				if (launch) begin
					frame_r <= {chip_r, map_r, wdata_i};
					bits_r <= 5'(`VOL_FRAME_BITS);
					div_r <= 8'h00;
					lclk_r <= 1'b0;
					st_r <= vol_pkg::H_SHIFT;
				end
			end
			vol_pkg::H_SHIFT: begin
				if (div_r == 8'(`VOL_LINK_HALF_CYC - 1)) begin
					div_r <= 8'h00;
					if (!lclk_r) begin
						lclk_r <= 1'b1;
					end else begin
						lclk_r <= 1'b0;
						frame_r <= {frame_r[22:0], 1'b0};
						bits_r <= bits_r - 5'h01;
						if (bits_r == 5'h01) begin
							st_r <= vol_pkg::H_GAP;
							gap_r <= 8'(`VOL_CSH_CYC);
						end
					end
				end else begin
					div_r <= div_r + 8'h01;
				end
			end
			vol_pkg::H_GAP: begin
				if (gap_r == 8'h00)
					st_r <= vol_pkg::H_IDLE;
				else
					gap_r <= gap_r - 8'h01;
			end
			default: st_r <= vol_pkg::H_IDLE;
			endcase
		end
	end

	// link pins straight from flops
	// data comes straight off the shifter so it moves with the falling clock
	logic sel_n_r;
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sel_n_r <= 1'b1;
		end else if (ce_i) begin
			sel_n_r <= !(st_r == vol_pkg::H_SHIFT ||
				(st_r == vol_pkg::H_IDLE && launch));
		end
	end

	assign link.reset_n = rst_pin_r;
	assign link.link_clk = lclk_r;
	assign link.sel_n = sel_n_r;
	assign link.sdata = frame_r[23];
endmodule : vol_host

// file: volume_power_sequencing_sva.sv
// checker for the serial link wires and the device channel outputs
// assumes it is instantiated beside the link interface in the bench top
module volume_power_sequencing_sva (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic reset_n,
	input wire logic link_clk,
	input wire logic sel_n,
	input wire logic sdata,
	input wire logic [7:0] amp_enable_o,
	input wire logic [7:0] chan_mute_o,
	input wire logic [87:0] chan_level_o
);
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	logic clk_q;
	logic [5:0] bit_cnt;
	logic [7:0] gap_cnt;
	// previous link clock, to find its rising edges
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			clk_q <= 1'b0;
		else
			clk_q <= link_clk;
	end
	// bits clocked in the open frame; cleared while deselected
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			bit_cnt <= 6'h00;
		else if (sel_n)
			bit_cnt <= 6'h00;
		else if (link_clk && !clk_q)
			bit_cnt <= bit_cnt + 6'h01;
	end
	// deselect time, saturating so long idles do not wrap
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			gap_cnt <= 8'hff; // idle link counts as a long gap
		else if (!sel_n)
			gap_cnt <= 8'h00;
		else if (gap_cnt != 8'hff)
			gap_cnt <= gap_cnt + 8'h01;
	end
	sequence s_high_half;
		link_clk [*8] ##1 !link_clk;
	endsequence
	sequence s_pin_low;
		!reset_n [*4];
	endsequence
	pin_low_off_a: assert property (s_pin_low |->
		amp_enable_o == 8'h00 && chan_mute_o == 8'hff)
		else $error("channel active while reset pin low");
	clk_idle_a: assert property (sel_n |-> !link_clk)
		else $error("link clock moves outside a frame");
	half_period_a: assert property ($rose(link_clk) |-> s_high_half)
		else $error("link clock high phase length wrong");
	sdata_edge_a: assert property (!sel_n && $changed(sdata) |->
		$fell(link_clk) || $fell(sel_n))
		else $error("serial data changed off the falling edge");
	frame_bits_a: assert property ($rose(sel_n) |-> bit_cnt == 6'h18)
		else $error("frame did not carry 24 bits");
	sel_gap_a: assert property ($fell(sel_n) |-> gap_cnt >= 8'hc8)
		else $error("deselect gap too short");
	pin_setup_a: assert property ($fell(sel_n) && reset_n |->
		$past(reset_n, 3))
		else $error("frame too soon after reset pin release");
	for (genvar i = 0; i < 8; i++) begin : g_ch
		vol_pkg::level_t lv;
		assign lv = chan_level_o[i*11 +: 11];
		sequence s_settle;
			chan_mute_o[i] [*8];
		endsequence
		settle_mute_a: assert property ($rose(amp_enable_o[i]) |-> s_settle)
			else $error("channel unmuted during amplifier settle");
		unmute_amp_a: assert property (!chan_mute_o[i] |-> amp_enable_o[i])
			else $error("unmuted channel without amplifier");
		mute_first_a: assert property ($fell(amp_enable_o[i]) |->
			chan_mute_o[i] && $past(chan_mute_o[i]))
			else $error("amplifier dropped before mute");
		level_span_a: assert property (lv <= 11'sh058 && lv >= 11'sh680)
			else $error("applied level outside span");
	end
endmodule : volume_power_sequencing_sva

// file: volume_power_sequencing_tb_top.sv
// bench: host end and device end joined by the link interface
// assumes the design files and vol_defs.svh are compiled first
`include "vol_defs.svh"
module volume_power_sequencing_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic [2:0] addr_i = 3'h0;
	logic [7:0] wdata_i = 8'h00;
	logic we_i = 1'b0;
	logic re_i = 1'b0;
	logic [7:0] zero_cross_i = 8'h00;
	logic [7:0] rdata_o;
	logic [7:0] amp_enable_o;
	logic [7:0] chan_mute_o;
	logic [87:0] chan_level_o;
	int error_cnt = 0;
	int n_compared = 0;
	// config, volumes, masters, group and foreign-address frames
	logic [23:0] setup_tab [15] = '{24'h0a_0a00, 24'h0a_0104,
		24'h0a_0901, 24'h0a_0efe, 24'h0a_1001, 24'h0a_0230, 24'h0a_1130,
		24'h0a_1302, 24'h0a_0390, 24'h0a_1490, 24'h0a_1604, 24'h0a_0bb3,
		24'h66_0502, 24'h20_0602, 24'h0a_0d80};
	logic [10:0] exp_lv [7] = '{11'h005, 11'h058, 11'h680, 11'h000,
		11'h004, 11'h000, 11'h000};
	always #2.5 core_clk_i = ~core_clk_i;
	vol_link_if vol_link_if_i ();
	vol_host vol_host_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
		.re_i(re_i), .rdata_o(rdata_o), .link(vol_link_if_i));
	vol_device #(.DEV_ADDR(7'h05), .MS_CYC(20)) vol_device_i (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.link(vol_link_if_i), .zero_cross_i(zero_cross_i),
		.amp_enable_o(amp_enable_o), .chan_mute_o(chan_mute_o),
		.chan_level_o(chan_level_o));
	volume_power_sequencing_sva volume_power_sequencing_sva_i (
		.core_clk_i(core_clk_i), .rst_i(rst_i),
		.reset_n(vol_link_if_i.reset_n), .link_clk(vol_link_if_i.link_clk),
		.sel_n(vol_link_if_i.sel_n), .sdata(vol_link_if_i.sdata),
		.amp_enable_o(amp_enable_o), .chan_mute_o(chan_mute_o),
		.chan_level_o(chan_level_o));
	task automatic give_verdict();
		if (error_cnt == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp8
	task automatic cmp11(input logic [10:0] got, input logic [10:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp11
	function automatic logic [10:0] lv(input int c);
		return chan_level_o[c*11 +: 11];
	endfunction : lv
	// waits, then lets the edge's updates land before sampling
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask : wt
	task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wdata_i <= d;
		we_i <= 1'b1;
		@(posedge core_clk_i);
		we_i <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		re_i <= 1'b1;
		@(posedge core_clk_i);
		re_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask : bus_rd
	task automatic zc_hit(input logic [7:0] m);
		@(posedge core_clk_i);
		zero_cross_i <= zero_cross_i ^ m;
	endtask : zc_hit
	// one whole frame, then bounded poll of busy
	task automatic frame(input logic [23:0] f);
		logic [7:0] st;
		int n;
		bus_wr(`VOL_H_CHIP, f[23:16]);
		bus_wr(`VOL_H_MAP, f[15:8]);
		bus_wr(`VOL_H_DATA, f[7:0]);
		bus_rd(`VOL_H_STATUS, st);
		cmp8(st, 8'h01);
		for (n = 0; n < 900 && st !== 8'h00; n++)
			bus_rd(`VOL_H_STATUS, st);
		cmp8(st, 8'h00);
	endtask : frame
	task automatic t_reset();
		logic [7:0] st;
		wt(2);
		cmp8(amp_enable_o, 8'h00);
		cmp8(chan_mute_o, 8'hff);
		frame(24'h0a_0c00);
		cmp8(amp_enable_o, 8'h00);
		bus_wr(`VOL_H_CTRL, 8'h01);
		bus_rd(`VOL_H_CTRL, st);
		cmp8(st, 8'h01);
		wt(100);
		cmp8(amp_enable_o, 8'h00);
	endtask : t_reset
	task automatic t_setup();
		// first entry selects immediate mode before power changes
		foreach (setup_tab[k])
			frame(setup_tab[k]);
		cmp8(amp_enable_o, 8'h00);
	endtask : t_setup
	task automatic t_power_up();
		frame(24'h0a_0c00);
		wt(20);
		cmp8(amp_enable_o, 8'h7f);
		cmp8(chan_mute_o, 8'hff);
		wt(2100);
		cmp8(chan_mute_o, 8'h80);
		for (int c = 0; c < 7; c++)
			cmp11(lv(c), exp_lv[c]);
	endtask : t_power_up
	// zero-cross mode, longest time-out, discard policy
	task automatic t_zc_timeout();
		frame(24'h0a_0a1d);
		frame(24'h0a_0402);
		wt(100);
		cmp11(lv(3), 11'h000);
		wt(1000);
		cmp11(lv(3), 11'h004);
	endtask : t_zc_timeout
	task automatic t_zc_cross();
		frame(24'h0a_0404);
		wt(20);
		cmp11(lv(3), 11'h004);
		// clock enable low: the crossing must wait until it returns
		@(posedge core_clk_i);
		ce_i <= 1'b0;
		zc_hit(8'h08);
		wt(10);
		cmp11(lv(3), 11'h004);
		@(posedge core_clk_i);
		ce_i <= 1'b1;
		wt(10);
		cmp11(lv(3), 11'h008);
	endtask : t_zc_cross
	// second command lands while the first is still pending
	task automatic t_policy();
		frame(24'h0a_0406);
		frame(24'h0a_0408);
		wt(500);
		cmp11(lv(3), 11'h008);
		wt(600);
		cmp11(lv(3), 11'h010);
		frame(24'h0a_0a1f);
		frame(24'h0a_040a);
		frame(24'h0a_040c);
		cmp11(lv(3), 11'h014);
		wt(1100);
		cmp11(lv(3), 11'h018);
	endtask : t_policy
	task automatic t_power_down();
		frame(24'h0a_0d81);
		cmp8(amp_enable_o, 8'h7f);
		zc_hit(8'h01);
		wt(10);
		cmp8(chan_mute_o, 8'h81);
		cmp8(amp_enable_o, 8'h7e);
		frame(24'h0a_0c01);
		zc_hit(8'hff);
		wt(10);
		cmp8(amp_enable_o, 8'h00);
		cmp8(chan_mute_o, 8'hff);
	endtask : t_power_down
	// pin reset must bring every setting back to default
	task automatic t_pin_reset();
		bus_wr(`VOL_H_CTRL, 8'h00);
		wt(10);
		cmp8(chan_mute_o, 8'hff);
		bus_wr(`VOL_H_CTRL, 8'h01);
		wt(10);
		frame(24'h0a_0c00);
		wt(2400);
		cmp8(amp_enable_o, 8'hff);
		cmp8(chan_mute_o, 8'h00);
		cmp11(lv(0), 11'h000);
		cmp11(lv(3), 11'h000);
	endtask : t_pin_reset
	initial begin
		repeat (16) @(posedge core_clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_setup();
		t_power_up();
		t_zc_timeout();
		t_zc_cross();
		t_policy();
		t_power_down();
		t_pin_reset();
		give_verdict();
	end
	// about three times the expected run length
	initial begin
		#400_000;
		error_cnt++;
		give_verdict();
	end
endmodule : volume_power_sequencing_tb_top
